// ### common/ext_bus_pkg.sv
package ext_bus_pkg;

   localparam int AW = 16;
   localparam int DW = 16;
   localparam int GLOBAL_AW = 15;
   localparam logic FLAG_RST = 1'b1;
   localparam logic [AW-1:0] ADDR_RST = 16'h0000;
   localparam logic [DW-1:0] DATA_RST = 16'h0000;

   typedef enum logic [1:0] {
      SP_PROG = 2'b00,
      SP_DATA = 2'b01,
      SP_IO = 2'b10,
      SP_GLOBAL = 2'b11
   } space_e;

   // Global space only spans 32K words, so the top address pin stays low
   function automatic logic [AW-1:0] pin_addr(input space_e sp, input logic [AW-1:0] a);
      if (sp == SP_GLOBAL) begin
         pin_addr = {{(AW-GLOBAL_AW){1'b0}}, a[GLOBAL_AW-1:0]};
      end else begin
         pin_addr = a;
      end
   endfunction

endpackage

// ### common/ram_access_if.sv
`timescale 1ns/100ps
interface ram_access_if;
   import ext_bus_pkg::*;
   logic hold_active;
   logic req_n;
   logic sel_n;
   logic rd;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic grant;
   logic rd_oe;
   logic [DW-1:0] rd_data;
   logic ram_en;
   logic ram_we;
   logic [AW-1:0] ram_addr;
   logic [DW-1:0] ram_wdata;
   logic [DW-1:0] ram_rdata;

   modport bus (
      output hold_active, req_n, sel_n, rd, addr, wdata, ram_rdata,
      input grant, rd_oe, rd_data, ram_en, ram_we, ram_addr, ram_wdata
   );
   modport ram (
      input hold_active, req_n, sel_n, rd, addr, wdata, ram_rdata,
      output grant, rd_oe, rd_data, ram_en, ram_we, ram_addr, ram_wdata
   );
endinterface

// ### core/ext_ram_access.sv
`timescale 1ns/100ps
module ext_ram_access
   import ext_bus_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic ce,
   // Link to the bus controller
   ram_access_if.ram acc
);

   logic grant_ff;
   logic sel_prev_ff;
   logic rd_pend_ff;
   logic en_ff;
   logic we_ff;
   logic [AW-1:0] addr_ff;
   logic [DW-1:0] wdata_ff;
   logic [DW-1:0] rdata_ff;
   logic access;

   // Strobe is sampled, so one access per falling edge however long it is held
   assign access = grant_ff && sel_prev_ff && !acc.sel_n;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         grant_ff <= 1'b0;
         sel_prev_ff <= 1'b1;
      end else if (ce) begin
         grant_ff <= acc.hold_active && !acc.req_n;
         sel_prev_ff <= acc.sel_n;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         en_ff <= 1'b0;
         we_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= ADDR_RST;
         wdata_ff <= DATA_RST;
      end else if (ce) begin
         en_ff <= access;
         we_ff <= access && !acc.rd;
         rd_pend_ff <= en_ff && !we_ff;
         if (access) begin
            addr_ff <= acc.addr;
            wdata_ff <= acc.wdata;
         end
      end
   end

   // RAM data is taken in the same cycle as the enable
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= DATA_RST;
      end else if (ce && en_ff && !we_ff) begin
         rdata_ff <= acc.ram_rdata;
      end
   end

   assign acc.grant = grant_ff;
   assign acc.rd_oe = grant_ff && !acc.sel_n && acc.rd;
   assign acc.rd_data = rdata_ff;
   assign acc.ram_en = en_ff;
   assign acc.ram_we = we_ff;
   assign acc.ram_addr = addr_ff;
   assign acc.ram_wdata = wdata_ff;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   dma_grant_a: assert property (ce && acc.hold_active && !acc.req_n |=> grant_ff)
      else $error("external RAM request not granted");
   dma_access_a: assert property (ce && access |=> en_ff && (we_ff == !$past(acc.rd)))
      else $error("external RAM access not issued");
   cov_dma_read_c: cover property (ce && access && acc.rd ##1 en_ff ##1 rd_pend_ff);
endmodule

// ### core/dsp_ext_bus_ctrl.sv
`timescale 1ns/100ps
module dsp_ext_bus_ctrl
   import ext_bus_pkg::*;
(
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic ce,
   // Core access request
   input wire logic core_req,
   input wire logic core_wr,
   input wire logic core_fetch,
   input wire logic core_vector,
   input wire space_e core_space,
   input wire logic [AW-1:0] core_addr,
   input wire logic [DW-1:0] core_wdata,
   output logic core_done,
   output logic [DW-1:0] core_rdata,
   // Core flag and branch test
   input wire logic flag_set,
   input wire logic flag_clr,
   input wire logic st1_wr,
   input wire logic st1_flag,
   input wire logic bio_sample,
   output logic bio_take,
   // On-chip RAM port for external access
   output logic ram_en,
   output logic ram_we,
   output logic [AW-1:0] ram_addr,
   output logic [DW-1:0] ram_wdata,
   input wire logic [DW-1:0] ram_rdata,
   // Input pins
   input wire logic float_n,
   input wire logic hold_request_n,
   input wire logic ready,
   input wire logic branch_test_input_n,
   // Address and data pins
   output logic [AW-1:0] addr_o,
   output logic addr_oe,
   input wire logic [AW-1:0] addr_i,
   output logic [DW-1:0] data_o,
   output logic data_oe,
   input wire logic [DW-1:0] data_i,
   // Memory control pins
   output logic prog_sel_n,
   output logic data_sel_n,
   output logic io_sel_n,
   output logic space_oe,
   output logic read_sel_n,
   output logic read_oe,
   output logic write_strobe_n,
   output logic write_strobe_oe,
   output logic rw_o,
   output logic rw_oe,
   input wire logic rw_i,
   output logic bus_cycle_select_n_o,
   output logic bus_cycle_select_oe,
   input wire logic bus_cycle_select_n_i,
   // Multiprocessing pins
   output logic global_bus_request_n_o,
   output logic global_bus_request_oe,
   input wire logic global_bus_request_n_i,
   output logic bus_hold_grant_n,
   output logic bus_hold_grant_oe,
   output logic instr_fetch_indicator_n,
   output logic instr_fetch_oe,
   output logic external_flag_out,
   output logic external_flag_oe,
   output logic interrupt_grant_n,
   output logic interrupt_grant_oe
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CYCLE = 2'b01,
      ST_END = 2'b10,
      ST_HOLD = 2'b11
   } bus_state_e;

   bus_state_e state_ff;
   bus_state_e nxt_state;
   logic wr_ff;
   logic fetch_ff;
   logic vec_ff;
   space_e space_ff;
   logic [AW-1:0] addr_ff;
   logic [DW-1:0] wdata_ff;
   logic [DW-1:0] rdata_ff;
   logic flag_ff;
   logic bio_ff;
   logic in_cycle;
   logic active;
   logic in_hold;
   logic drive;
   logic launch;

   ram_access_if acc ();

   ext_ram_access u_ram_access (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .ce(ce),
      .acc(acc.ram)
   );

   assign in_cycle = (state_ff == ST_CYCLE);
   assign active = in_cycle || (state_ff == ST_END);
   assign in_hold = (state_ff == ST_HOLD);
   // Hold is only taken between cycles, so a started access always completes
   assign drive = float_n && !in_hold;
   assign launch = (state_ff == ST_IDLE) && hold_request_n && core_req;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (!hold_request_n) begin
               nxt_state = ST_HOLD;
            end else if (core_req) begin
               nxt_state = ST_CYCLE;
            end
         end
         ST_CYCLE: begin
            if (ready) begin
               nxt_state = ST_END;
            end
         end
         ST_END: begin
            nxt_state = ST_IDLE;
         end
         // Hold lasts exactly as long as the requester keeps it, with no limit of its own
         ST_HOLD: begin
            if (hold_request_n) begin
               nxt_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= ST_IDLE;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   // Request fields are captured once so the core may change them after done
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ff <= 1'b0;
         fetch_ff <= 1'b0;
         vec_ff <= 1'b0;
         space_ff <= SP_PROG;
         addr_ff <= ADDR_RST;
         wdata_ff <= DATA_RST;
      end else if (ce && launch) begin
         wr_ff <= core_wr;
         fetch_ff <= core_fetch;
         vec_ff <= core_vector;
         space_ff <= core_space;
         addr_ff <= pin_addr(core_space, core_addr);
         wdata_ff <= core_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= DATA_RST;
      end else if (ce && in_cycle && ready && !wr_ff) begin
         rdata_ff <= data_i;
      end
   end

   // Status write wins over set and clear; no hardware event touches the flag
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_ff <= FLAG_RST;
      end else if (ce) begin
         if (st1_wr) begin
            flag_ff <= st1_flag;
         end else if (flag_set) begin
            flag_ff <= 1'b1;
         end else if (flag_clr) begin
            flag_ff <= 1'b0;
         end
      end
   end

   // Sampled only on request, so the result stays put for the branch decision
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bio_ff <= 1'b0;
      end else if (ce && bio_sample) begin
         bio_ff <= !branch_test_input_n;
      end
   end

   assign core_done = (state_ff == ST_END);
   assign core_rdata = rdata_ff;
   assign bio_take = bio_ff;

   assign acc.hold_active = in_hold;
   assign acc.req_n = global_bus_request_n_i;
   assign acc.sel_n = bus_cycle_select_n_i;
   assign acc.rd = rw_i;
   assign acc.addr = addr_i;
   assign acc.wdata = data_i;
   assign acc.ram_rdata = ram_rdata;
   assign ram_en = acc.ram_en;
   assign ram_we = acc.ram_we;
   assign ram_addr = acc.ram_addr;
   assign ram_wdata = acc.ram_wdata;

   assign addr_o = addr_ff;
   assign addr_oe = drive;
   assign data_o = in_hold ? acc.rd_data : wdata_ff;
   // Data stays driven through the end cycle to cover the strobe's rising edge
   assign data_oe = float_n && ((drive && active && wr_ff) || (in_hold && acc.rd_oe));
   assign prog_sel_n = !(active && space_ff == SP_PROG);
   assign data_sel_n = !(active && (space_ff == SP_DATA || space_ff == SP_GLOBAL));
   assign io_sel_n = !(active && space_ff == SP_IO);
   assign space_oe = drive;
   assign read_sel_n = !(in_cycle && !wr_ff);
   assign read_oe = drive;
   assign write_strobe_n = !(in_cycle && wr_ff);
   assign write_strobe_oe = drive;
   assign rw_o = !(active && wr_ff);
   assign rw_oe = drive;
   assign bus_cycle_select_n_o = !in_cycle;
   assign bus_cycle_select_oe = drive;
   assign global_bus_request_n_o = !(active && space_ff == SP_GLOBAL);
   assign global_bus_request_oe = drive;
   assign bus_hold_grant_n = !in_hold;
   assign bus_hold_grant_oe = float_n;
   // In hold the fetch pin turns into the grant for external RAM access
   assign instr_fetch_indicator_n = in_hold ? !acc.grant : !(active && fetch_ff);
   assign instr_fetch_oe = float_n;
   assign external_flag_out = flag_ff;
   assign external_flag_oe = float_n;
   assign interrupt_grant_n = !(active && vec_ff);
   assign interrupt_grant_oe = float_n;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   we_data_drive_a: assert property (!write_strobe_n |-> data_oe || !float_n)
      else $error("write strobe low without data drive");
   we_any_space_a: assert property (ce && launch && core_wr |=> !write_strobe_n)
      else $error("write strobe missing on write");
   we_float_a: assert property (in_hold || !float_n |-> !write_strobe_oe)
      else $error("write strobe driven in hold or float");
   hold_lines_a: assert property (!bus_hold_grant_n |-> !addr_oe && !space_oe && !rw_oe && !read_oe)
      else $error("lines driven during hold");
   hold_entry_a: assert property (ce && state_ff == ST_IDLE && !hold_request_n |=> !bus_hold_grant_n)
      else $error("hold not granted in one cycle");
   hold_exit_a: assert property (ce && in_hold && hold_request_n |=> bus_hold_grant_n)
      else $error("hold grant kept after release");
   grant_float_a: assert property (!float_n |-> !bus_hold_grant_oe && !external_flag_oe)
      else $error("grant or flag driven in float");
   global_req_a: assert property (ce && launch && core_space == SP_GLOBAL |=> !global_bus_request_n_o [*2])
      else $error("bus request not held over global access");
   global_addr_a: assert property (active && space_ff == SP_GLOBAL |-> !addr_o[AW-1])
      else $error("global address beyond 32K");
   fetch_flag_a: assert property (ce && launch && core_fetch |=> !instr_fetch_indicator_n [*2])
      else $error("fetch indicator missing");
   fetch_grant_a: assert property (ce && in_hold && !hold_request_n && !acc.req_n
      |=> !instr_fetch_indicator_n)
      else $error("fetch indicator not granting in hold");
   bio_sample_a: assert property (ce && bio_sample |=> bio_take == !$past(branch_test_input_n))
      else $error("branch test sampled wrong");
   flag_keep_a: assert property (!(ce && (flag_set || flag_clr || st1_wr)) |=> $stable(external_flag_out))
      else $error("flag changed without a write");
   vector_ack_a: assert property (ce && launch && core_vector |=> !interrupt_grant_n ##1 !interrupt_grant_n)
      else $error("interrupt grant missing on vector fetch");
   float_ctrl_a: assert property (!float_n |-> !interrupt_grant_oe && !instr_fetch_oe)
      else $error("fetch or interrupt output driven in float");
   ready_wait_a: assert property (ce && in_cycle && !ready |=> in_cycle)
      else $error("cycle ended with ready low");

   we_release_a: assert property (ce && in_cycle && wr_ff && ready |=> write_strobe_n && (data_oe || !float_n))
      else $error("data not held over write strobe rise");
   hold_mem_ctrl_a: assert property (!bus_hold_grant_n |-> !write_strobe_oe && !bus_cycle_select_oe
      && !global_bus_request_oe)
      else $error("memory control driven during hold");
   hold_data_a: assert property (in_hold && !acc.rd_oe |-> !data_oe)
      else $error("data bus driven during hold");
   cycle_no_hold_a: assert property (ce && launch |=> bus_hold_grant_n)
      else $error("hold grant during a bus cycle");
   global_end_a: assert property (ce && core_done |=> global_bus_request_n_o)
      else $error("bus request kept after access");
   vector_end_a: assert property (ce && core_done |=> interrupt_grant_n)
      else $error("interrupt grant kept after access");
   // Flag priority: status write, then set, then clear
   flag_set_a: assert property (ce && flag_set && !st1_wr |=> external_flag_out)
      else $error("flag not set");
   flag_clr_a: assert property (ce && flag_clr && !flag_set && !st1_wr |=> !external_flag_out)
      else $error("flag not cleared");
   st1_load_a: assert property (ce && st1_wr |=> external_flag_out == $past(st1_flag))
      else $error("flag not loaded from status write");

   cov_write_c: cover property (ce && launch && core_wr ##1 in_cycle ##1 state_ff == ST_END);
   cov_wait_c: cover property (in_cycle && !ready ##1 in_cycle && ready);
   cov_hold_c: cover property (in_hold ##1 acc.grant);
   cov_global_c: cover property (ce && launch && core_space == SP_GLOBAL ##1 in_cycle ##1 in_cycle ##1 core_done);
endmodule

// ### testbench/ext_mem_model.sv
`timescale 1ns/100ps
module ext_mem_model
   import ext_bus_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Bus pins as the memory sees them
   input wire logic [AW-1:0] addr_o,
   input wire logic [DW-1:0] data_o,
   input wire logic write_strobe_n,
   input wire logic read_sel_n,
   input wire logic slow,
   // Answer to the device
   output logic ready,
   output logic [DW-1:0] mem_data
);
   logic [DW-1:0] mem [16];
   logic [DW-1:0] last_ff;
   logic wait_ff;

   always @(posedge write_strobe_n) begin
      mem[addr_o[3:0]] <= data_o;
   end

   // One wait state per cycle when slow, so the ready retry path is exercised
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_ff <= 1'b0;
      end else begin
         wait_ff <= !(read_sel_n && write_strobe_n);
      end
   end

   assign ready = !slow || wait_ff;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         last_ff <= 16'h0000;
      end else if (!read_sel_n) begin
         last_ff <= mem[addr_o[3:0]];
      end
   end

   // A released bus never shows the last value, or a late sample would pass by luck
   assign mem_data = !read_sel_n ? mem[addr_o[3:0]] : ~last_ff;
endmodule

// ### testbench/dsp_external_bus_hold_control_tb.sv
`timescale 1ns/100ps
module dsp_external_bus_hold_control_tb import ext_bus_pkg::*;;
   logic ref_clk = 1'b0;
   logic arst_n, ce, core_req, core_wr, core_fetch, core_vector, core_done, flag_set, flag_clr, st1_wr;
   logic st1_flag, bio_sample, bio_take, ram_en, ram_we, float_n, hold_request_n, ready, branch_test_input_n;
   logic addr_oe, data_oe, prog_sel_n, data_sel_n, io_sel_n, space_oe, read_sel_n, read_oe, write_strobe_n;
   logic write_strobe_oe, rw_o, rw_oe, rw_i, bus_cycle_select_n_o, bus_cycle_select_oe, bus_cycle_select_n_i;
   logic global_bus_request_n_o, global_bus_request_oe, global_bus_request_n_i, bus_hold_grant_n;
   logic bus_hold_grant_oe, instr_fetch_indicator_n, instr_fetch_oe, external_flag_out, external_flag_oe;
   logic interrupt_grant_n, interrupt_grant_oe, rw_drv, bus_cycle_select_n_drv, br_drv, dma_on, slow;
   space_e core_space;
   logic [AW-1:0] core_addr, addr_o, addr_i, addr_drv, ram_addr;
   logic [DW-1:0] core_wdata, core_rdata, data_o, data_i, ram_wdata, ram_rdata, dma_data, mem_data;
   logic [DW-1:0] exp_mem [16];
   logic [DW-1:0] exp_q [$];
   int fails = 0;
   int checks = 0;
   int cyc = 0;

   // Pin levels resolved from every party's enable
   assign addr_i = addr_oe ? addr_o : addr_drv;
   assign data_i = data_oe ? data_o : (dma_on ? dma_data : mem_data);
   assign rw_i = rw_oe ? rw_o : rw_drv;
   assign bus_cycle_select_n_i = bus_cycle_select_oe ? bus_cycle_select_n_o : bus_cycle_select_n_drv;
   assign global_bus_request_n_i = global_bus_request_oe ? global_bus_request_n_o : br_drv;

   dsp_ext_bus_ctrl dsp_ext_bus_ctrl_inst (.ref_clk, .arst_n, .ce, .core_req, .core_wr, .core_fetch,
      .core_vector, .core_space, .core_addr, .core_wdata, .core_done, .core_rdata, .flag_set, .flag_clr,
      .st1_wr, .st1_flag, .bio_sample, .bio_take, .ram_en, .ram_we, .ram_addr, .ram_wdata, .ram_rdata,
      .float_n, .hold_request_n, .ready, .branch_test_input_n, .addr_o, .addr_oe, .addr_i, .data_o, .data_oe,
      .data_i, .prog_sel_n, .data_sel_n, .io_sel_n, .space_oe, .read_sel_n, .read_oe, .write_strobe_n,
      .write_strobe_oe, .rw_o, .rw_oe, .rw_i, .bus_cycle_select_n_o, .bus_cycle_select_oe,
      .bus_cycle_select_n_i, .global_bus_request_n_o, .global_bus_request_oe, .global_bus_request_n_i,
      .bus_hold_grant_n, .bus_hold_grant_oe, .instr_fetch_indicator_n, .instr_fetch_oe, .external_flag_out,
      .external_flag_oe, .interrupt_grant_n, .interrupt_grant_oe);

   ext_mem_model ext_mem_model_inst (.ref_clk, .arst_n, .addr_o, .data_o, .write_strobe_n, .read_sel_n,
      .slow, .ready, .mem_data);

   always #5 ref_clk = ~ref_clk;

   task automatic end_sim();
      if (fails == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic compare_word(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic compare_bit(input logic got, input logic exp);
      compare_word({15'h0000, got}, {15'h0000, exp});
   endtask

   // Hang guard: the whole sequence needs about a hundred and ten cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         end_sim();
      end
   end

   always @(negedge ref_clk) begin
      if (core_done === 1'b1 && core_wr === 1'b0) begin
         compare_word(core_rdata, exp_q.pop_front());
      end
   end

   task automatic access(input logic wr, input space_e sp, input logic [15:0] a, input logic [15:0] d,
                         input logic f, input logic v, input logic s);
      int n;
      @(posedge ref_clk);
      core_req <= 1'b1;
      core_wr <= wr;
      core_space <= sp;
      core_addr <= a;
      core_wdata <= d;
      core_fetch <= f;
      core_vector <= v;
      slow <= s;
      if (wr) exp_mem[a[3:0]] = d;
      else exp_q.push_back(exp_mem[a[3:0]]);
      // The request is taken at the next edge and the cycle shows after it
      @(posedge ref_clk);
      @(negedge ref_clk);
      compare_bit(wr ? write_strobe_n : read_sel_n, 1'b0);
      if (wr) compare_word(data_oe ? data_o : 16'hDEAD, d);
      compare_word(addr_o, sp == SP_GLOBAL ? {1'b0, a[14:0]} : a);
      compare_bit(global_bus_request_n_o, sp != SP_GLOBAL);
      compare_bit(instr_fetch_indicator_n, !f);
      compare_bit(interrupt_grant_n, !v);
      n = 0;
      while (core_done !== 1'b1 && n < 8) begin
         @(negedge ref_clk);
         n++;
      end
      compare_word(16'(n), s ? 16'h0002 : 16'h0001);
      @(posedge ref_clk);
      core_req <= 1'b0;
   endtask

   task automatic flag_op(input logic s, input logic c, input logic w, input logic v, input logic e);
      @(posedge ref_clk);
      flag_set <= s;
      flag_clr <= c;
      st1_wr <= w;
      st1_flag <= v;
      @(posedge ref_clk);
      flag_set <= 1'b0;
      flag_clr <= 1'b0;
      st1_wr <= 1'b0;
      @(negedge ref_clk);
      compare_bit(external_flag_out, e);
   endtask

   initial begin
      logic [AW-1:0] a;
      logic [DW-1:0] d;
      int n;
      arst_n = 1'b0; ce = 1'b1; core_req = 1'b0; core_wr = 1'b0; core_fetch = 1'b0; core_vector = 1'b0;
      core_space = SP_PROG; core_addr = 16'h0000; core_wdata = 16'h0000; flag_set = 1'b0; flag_clr = 1'b0;
      st1_wr = 1'b0; st1_flag = 1'b0; bio_sample = 1'b0; float_n = 1'b1; hold_request_n = 1'b1;
      branch_test_input_n = 1'b1; addr_drv = 16'h0000; rw_drv = 1'b1; bus_cycle_select_n_drv = 1'b1; br_drv = 1'b1;
      dma_on = 1'b0; dma_data = 16'h0000; slow = 1'b0; ram_rdata = 16'h0000;
      void'($urandom(32'hB094AF35));
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(negedge ref_clk);
      compare_bit(external_flag_out, 1'b1);
      for (int i = 0; i < 8; i++) begin
         a = {12'($urandom), i[3:0]};
         access(1'b1, space_e'(i[1:0]), a, 16'($urandom), 1'b0, 1'b0, i[0]);
         access(1'b0, space_e'(i[2:1]), a, 16'h0000, i[1] | i[2], i[2], i[1]);
      end
      @(posedge ref_clk);
      hold_request_n <= 1'b0;
      repeat (2) @(negedge ref_clk);
      compare_bit(bus_hold_grant_n, 1'b0);
      compare_bit(addr_oe | data_oe | space_oe | read_oe | rw_oe | bus_cycle_select_oe, 1'b0);
      compare_bit(write_strobe_oe, 1'b0);
      @(posedge ref_clk);
      br_drv <= 1'b0;
      repeat (3) @(negedge ref_clk);
      compare_bit(instr_fetch_indicator_n, 1'b0);
      a = 16'($urandom);
      d = 16'($urandom);
      @(posedge ref_clk);
      addr_drv <= a;
      dma_data <= d;
      dma_on <= 1'b1;
      rw_drv <= 1'b0;
      bus_cycle_select_n_drv <= 1'b0;
      n = 0;
      while (ram_en !== 1'b1 && n < 5) begin
         @(negedge ref_clk);
         n++;
      end
      compare_bit(ram_en, 1'b1);
      compare_bit(ram_we, 1'b1);
      compare_word(ram_addr, a);
      compare_word(ram_wdata, d);
      a = 16'($urandom);
      d = 16'($urandom);
      @(posedge ref_clk);
      bus_cycle_select_n_drv <= 1'b1;
      dma_on <= 1'b0;
      rw_drv <= 1'b1;
      @(posedge ref_clk);
      addr_drv <= a;
      ram_rdata <= d;
      bus_cycle_select_n_drv <= 1'b0;
      n = 0;
      while (ram_en !== 1'b1 && n < 5) begin
         @(negedge ref_clk);
         n++;
      end
      compare_bit(ram_en, 1'b1);
      compare_bit(ram_we, 1'b0);
      compare_word(ram_addr, a);
      @(negedge ref_clk);
      compare_bit(data_oe, 1'b1);
      compare_word(data_o, d);
      @(posedge ref_clk);
      bus_cycle_select_n_drv <= 1'b1;
      br_drv <= 1'b1;
      hold_request_n <= 1'b1;
      repeat (2) @(negedge ref_clk);
      compare_bit(bus_hold_grant_n, 1'b1);
      flag_op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      flag_op(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
      flag_op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      flag_op(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
      // With the clock enable low a clear must leave the flag alone
      @(posedge ref_clk);
      ce <= 1'b0;
      flag_op(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      @(posedge ref_clk);
      ce <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         d[0] = 1'($urandom);
         @(posedge ref_clk);
         branch_test_input_n <= d[0];
         bio_sample <= 1'b1;
         @(posedge ref_clk);
         bio_sample <= 1'b0;
         @(negedge ref_clk);
         compare_bit(bio_take, !d[0]);
      end
      @(posedge ref_clk);
      float_n <= 1'b0;
      @(negedge ref_clk);
      compare_bit(write_strobe_oe | bus_hold_grant_oe, 1'b0);
      compare_bit(external_flag_oe, 1'b0);
      compare_bit(interrupt_grant_oe | instr_fetch_oe, 1'b0);
      end_sim();
   end
endmodule
